/* core/modem_dma_pkg.sv */
/*
   shared constants and carrier types for the modem input, isochronous clock
   and dma ready block of a four channel uart.
   assumes an apb slave at 32 bit data, one aligned word per register.
*/
package modem_dma_pkg;

   localparam int CHANNELS = 4;
   localparam int ADDR_W = 8;

   // register byte offsets
   localparam logic [ADDR_W-1:0] MSR_BASE = 8'h00;
   localparam logic [ADDR_W-1:0] CKS_BASE = 8'h10;
   localparam logic [ADDR_W-1:0] CTRL_ADDR = 8'h20;
   localparam logic [ADDR_W-1:0] INT_STATUS_ADDR = 8'h24;
   localparam logic [ADDR_W-1:0] INT_MASK_ADDR = 8'h28;
   localparam logic [ADDR_W-1:0] BLOCK_MASK = 8'hF0;
   localparam logic [ADDR_W-1:0] INDEX_MASK = 8'h0C;
   localparam int INDEX_LSB = 2;

   // modem status register bit positions
   localparam int MSR_CTS_BIT = 4;
   localparam int MSR_DSR_BIT = 5;
   localparam int MSR_RI_BIT = 6;
   localparam int MSR_DCD_BIT = 7;

   // clock select field
   localparam int CKS_W = 8;
   localparam logic [1:0] CKS_RX_EXT = 2'h1;
   localparam int CKS_TX_EXT_BIT = 6;
   localparam logic [CKS_W-1:0] CKS_RESET = 8'h00;

   // control register fields
   localparam int CTRL_W = 12;
   localparam int CTRL_DSR_EN_LSB = 0;
   localparam int CTRL_CTS_EN_LSB = 4;
   localparam int CTRL_DMA_MODE_LSB = 8;
   localparam logic [CTRL_W-1:0] CTRL_RESET = 12'h000;

   // interrupt status / mask layout
   localparam int INT_W = 8;
   localparam int INT_MODEM_LSB = 0;
   localparam int INT_HALT_LSB = 4;
   localparam logic [INT_W-1:0] INT_RESET = 8'h00;

   localparam logic [31:0] RDATA_ZERO = 32'h00000000;

   typedef enum logic [1:0]
   {
      FLOW_RUN = 2'b00,
      FLOW_DRAIN = 2'b01,
      FLOW_HALT = 2'b10
   } flow_state_t;

   // modem pins, all active low, one bit per channel
   typedef struct packed
   {
      logic [CHANNELS-1:0] clear_to_send_n;
      logic [CHANNELS-1:0] data_set_ready_n;
      logic [CHANNELS-1:0] carrier_detect_n;
      logic [CHANNELS-1:0] ring_indicator_n;
   } modem_pins_t;

   localparam int MODEM_W = 4 * CHANNELS;
   localparam logic [MODEM_W-1:0] MODEM_IDLE = 16'hFFFF;

   // levels from the uart core, active high
   typedef struct packed
   {
      logic [CHANNELS-1:0] tx_busy;
      logic [CHANNELS-1:0] flow_char_pending;
      logic [CHANNELS-1:0] baud_tick;
      logic [CHANNELS-1:0] tx_dma_single;
      logic [CHANNELS-1:0] tx_dma_multi;
      logic [CHANNELS-1:0] rx_dma_single;
      logic [CHANNELS-1:0] rx_dma_multi;
   } core_in_t;

   typedef struct packed
   {
      logic [CHANNELS-1:0] tx_go;
      logic [CHANNELS-1:0] tx_clk_tick;
      logic [CHANNELS-1:0] rx_clk_tick;
   } core_out_t;

   typedef struct packed
   {
      logic [CHANNELS-1:0] tx_dma_ready_n;
      logic [CHANNELS-1:0] rx_dma_ready_n;
      logic tx_dma_ready_all_n;
      logic rx_dma_ready_all_n;
   } dma_pins_t;

endpackage

/* core/pin_sync.sv */
/*
   two flip-flop synchroniser for a vector of asynchronous pin levels.
   assumes each bit is an independent level; no bus coherence is given.
*/
`timescale 1ns/1ps
module pin_sync
#(
   parameter int WIDTH = 16,
   parameter logic [WIDTH-1:0] IDLE = '1
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [WIDTH-1:0] pin_async,
   output logic [WIDTH-1:0] pin_sync_ff
);

   typedef struct packed
   {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
   } sync_state_t;

   sync_state_t state_ff;
   sync_state_t nxt_state;

   // first stage feeds only the second stage
   always_comb
   begin
      nxt_state.meta = pin_async;
      nxt_state.stable = state_ff.meta;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_ff <= {IDLE, IDLE};
      end
      else
      begin
         state_ff <= nxt_state;
      end
   end

   assign pin_sync_ff = state_ff.stable;

endmodule

/* core/modem_dma_block.sv */
/*
   modem status inputs, flow control gating, isochronous clock pin selection
   and dma ready outputs for four uart channels, with an apb register slave.
   assumes the uart core starts a character only while tx_go is high and
   raises tx_busy for the whole character; pins are asynchronous to pclk.
   assumes a pin used as a clock stays high and low for two pclk at least;
   such a pin sets its modem change bit on every edge, so software masks
   that bit while the clock runs. a status read clears every bit set at its
   completing edge, one set a cycle after the data was taken included.
*/
`timescale 1ns/1ps

// Function
// RL1: dsr autoflow on and dsr deasserted: finish current character, then idle until reasserted.
// RL2: in-band flow characters still go out while dsr autoflow holds the transmitter.
// RL3: data-set-ready pin state shows in modem status bit 5.
// RL4: carrier-detect pin state shows in modem status bit 7.
// RL5: ring-indicator pin state shows in modem status bit 6.
// RL6: every modem input readable as a general-purpose input via status bits.
// RL7: clock select low bits 01 take receive clock from the dsr pin.
// RL8: clock select bit 6 takes transmit clock from ring pin, receiver indirectly.
// RL9: ring pin can serve as 1x clock for both transmitter and receiver.
// RL10: each channel drives its own active-low transmit dma ready output.
// RL11: combined active-low transmit dma ready asserts when any channel's does.
// RL12: each channel drives its own active-low receive dma ready output.
// RL13: combined active-low receive dma ready asserts when any channel's does.
// RL14: dma ready outputs offer two selectable signalling modes.
// RL15: cts autoflow likewise stops after current character; cts shows in status bit 4.
// RL16: all modem inputs pass a two-stage synchroniser before any use.
module modem_dma_block
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [modem_dma_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq,
   input wire modem_dma_pkg::modem_pins_t modem_pins_n,
   input wire modem_dma_pkg::core_in_t core_in,
   output modem_dma_pkg::core_out_t core_out,
   output modem_dma_pkg::dma_pins_t dma_pins
);

   localparam int CH = modem_dma_pkg::CHANNELS;
   localparam int CKS_RX_W = $bits(modem_dma_pkg::CKS_RX_EXT);

   typedef struct packed
   {
      modem_dma_pkg::modem_pins_t prev;
      modem_dma_pkg::flow_state_t [CH-1:0] flow;
      logic [CH-1:0][modem_dma_pkg::CKS_W-1:0] clock_select_field;
      logic [modem_dma_pkg::CTRL_W-1:0] ctrl;
      logic [modem_dma_pkg::INT_W-1:0] int_status;
      logic [modem_dma_pkg::INT_W-1:0] int_mask;
      logic irq;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      modem_dma_pkg::core_out_t core_out;
      modem_dma_pkg::dma_pins_t dma;
   } block_state_t;

   block_state_t state_ff;
   block_state_t nxt_state;
   modem_dma_pkg::modem_pins_t pins_sync;

   // every modem pin synchronised before flow, clocks or status see it
   pin_sync
   #(
      .WIDTH(modem_dma_pkg::MODEM_W),
      .IDLE(modem_dma_pkg::MODEM_IDLE)
   )
   u_pin_sync
   (
      .pclk(pclk),
      .presetn(presetn),
      .pin_async(modem_pins_n),
      .pin_sync_ff(pins_sync)
   ); // see RL16

   always_comb
   begin
      logic setup_done;
      logic access_end;
      logic is_read;
      logic [modem_dma_pkg::ADDR_W-1:0] base;
      logic [1:0] idx;
      logic mapped;
      logic [31:0] rd;
      logic [CH-1:0] stop;
      logic [CH-1:0] modem_change;
      logic [CH-1:0] halt_entry;
      logic [CH-1:0] dsr_rise;
      logic [CH-1:0] ri_rise;
      logic [CH-1:0] rx_from_dsr;
      logic [CH-1:0] tick_from_ring;
      logic [CH-1:0] tx_req;
      logic [CH-1:0] rx_req;
      logic [modem_dma_pkg::INT_W-1:0] int_set;
      logic [modem_dma_pkg::INT_W-1:0] int_clr;
      logic [CH-1:0] dsr_en;
      logic [CH-1:0] cts_en;
      logic [CH-1:0] dma_mode;

      nxt_state = state_ff;
      setup_done = psel && penable && !state_ff.pready;
      access_end = psel && penable && state_ff.pready;
      is_read = !pwrite;
      base = paddr & modem_dma_pkg::BLOCK_MASK;
      idx = paddr[modem_dma_pkg::INDEX_LSB +: 2];
      mapped = 1'b0;
      rd = modem_dma_pkg::RDATA_ZERO;
      stop = '0;
      modem_change = '0;
      halt_entry = '0;
      dsr_rise = '0;
      ri_rise = '0;
      rx_from_dsr = '0;
      tick_from_ring = '0;
      tx_req = '0;
      rx_req = '0;
      int_set = modem_dma_pkg::INT_RESET;
      int_clr = modem_dma_pkg::INT_RESET;
      dsr_en = state_ff.ctrl[modem_dma_pkg::CTRL_DSR_EN_LSB +: CH];
      cts_en = state_ff.ctrl[modem_dma_pkg::CTRL_CTS_EN_LSB +: CH];
      dma_mode = state_ff.ctrl[modem_dma_pkg::CTRL_DMA_MODE_LSB +: CH];

      // third stage feeds only edge and change detection
      nxt_state.prev = pins_sync;

      // per channel: flow gating, clock picks and dma pins
      for (int c = 0; c < CH; c++)
      begin
         // either autoflow source stops new characters
         stop[c] = (dsr_en[c] && pins_sync.data_set_ready_n[c])
            || (cts_en[c] && pins_sync.clear_to_send_n[c]); // see RL1 see RL15
         case (state_ff.flow[c])
            modem_dma_pkg::FLOW_RUN:
            begin
               if (stop[c])
               begin
                  halt_entry[c] = 1'b1;
                  // character on the line is never cut short
                  if (core_in.tx_busy[c])
                  begin
                     nxt_state.flow[c] = modem_dma_pkg::FLOW_DRAIN; // see RL1
                  end
                  else
                  begin
                     nxt_state.flow[c] = modem_dma_pkg::FLOW_HALT;
                  end
               end
            end
            modem_dma_pkg::FLOW_DRAIN:
            begin
               if (!stop[c])
               begin
                  nxt_state.flow[c] = modem_dma_pkg::FLOW_RUN;
               end
               else if (!core_in.tx_busy[c])
               begin
                  nxt_state.flow[c] = modem_dma_pkg::FLOW_HALT; // see RL1 see RL15
               end
            end
            modem_dma_pkg::FLOW_HALT:
            begin
               if (!stop[c])
               begin
                  nxt_state.flow[c] = modem_dma_pkg::FLOW_RUN;
               end
            end
            default:
            begin
               nxt_state.flow[c] = modem_dma_pkg::FLOW_RUN;
            end
         endcase
         // flow characters bypass the hold
         nxt_state.core_out.tx_go[c] = (nxt_state.flow[c] == modem_dma_pkg::FLOW_RUN)
            || core_in.flow_char_pending[c]; // see RL2

         modem_change[c] = (pins_sync.clear_to_send_n[c] != state_ff.prev.clear_to_send_n[c])
            || (pins_sync.data_set_ready_n[c] != state_ff.prev.data_set_ready_n[c])
            || (pins_sync.carrier_detect_n[c] != state_ff.prev.carrier_detect_n[c])
            || (pins_sync.ring_indicator_n[c] != state_ff.prev.ring_indicator_n[c]);

         // pin clocks must stay below pclk / 4 to be seen edge by edge
         dsr_rise[c] = pins_sync.data_set_ready_n[c] && !state_ff.prev.data_set_ready_n[c];
         ri_rise[c] = pins_sync.ring_indicator_n[c] && !state_ff.prev.ring_indicator_n[c];
         tick_from_ring[c] = state_ff.clock_select_field[c][modem_dma_pkg::CKS_TX_EXT_BIT];
         rx_from_dsr[c] = state_ff.clock_select_field[c][CKS_RX_W-1:0] == modem_dma_pkg::CKS_RX_EXT;
         if (tick_from_ring[c])
         begin
            nxt_state.core_out.tx_clk_tick[c] = ri_rise[c]; // see RL8 see RL9
         end
         else
         begin
            nxt_state.core_out.tx_clk_tick[c] = core_in.baud_tick[c];
         end
         if (rx_from_dsr[c])
         begin
            nxt_state.core_out.rx_clk_tick[c] = dsr_rise[c]; // see RL7
         end
         else if (tick_from_ring[c])
         begin
            nxt_state.core_out.rx_clk_tick[c] = ri_rise[c]; // see RL8 see RL9
         end
         else
         begin
            nxt_state.core_out.rx_clk_tick[c] = core_in.baud_tick[c];
         end

         // mode picks which core request drives the pin
         tx_req[c] = dma_mode[c] ? core_in.tx_dma_multi[c] : core_in.tx_dma_single[c]; // see RL14
         rx_req[c] = dma_mode[c] ? core_in.rx_dma_multi[c] : core_in.rx_dma_single[c]; // see RL14
         nxt_state.dma.tx_dma_ready_n[c] = !tx_req[c]; // see RL10
         nxt_state.dma.rx_dma_ready_n[c] = !rx_req[c]; // see RL12
      end

      // combined pins from the same requests, so they never lag a channel pin
      nxt_state.dma.tx_dma_ready_all_n = !(|tx_req); // see RL11
      nxt_state.dma.rx_dma_ready_all_n = !(|rx_req); // see RL13

      int_set[modem_dma_pkg::INT_MODEM_LSB +: CH] = modem_change;
      int_set[modem_dma_pkg::INT_HALT_LSB +: CH] = halt_entry;

      // read data captured one cycle into the access phase
      if (base == modem_dma_pkg::MSR_BASE)
      begin
         mapped = 1'b1;
         rd[modem_dma_pkg::MSR_CTS_BIT] = !pins_sync.clear_to_send_n[idx]; // see RL15
         rd[modem_dma_pkg::MSR_DSR_BIT] = !pins_sync.data_set_ready_n[idx]; // see RL3 see RL6
         rd[modem_dma_pkg::MSR_RI_BIT] = !pins_sync.ring_indicator_n[idx]; // see RL5 see RL6
         rd[modem_dma_pkg::MSR_DCD_BIT] = !pins_sync.carrier_detect_n[idx]; // see RL4 see RL6
      end
      else if (base == modem_dma_pkg::CKS_BASE)
      begin
         mapped = 1'b1;
         rd[modem_dma_pkg::CKS_W-1:0] = state_ff.clock_select_field[idx];
      end
      else if (paddr == modem_dma_pkg::CTRL_ADDR)
      begin
         mapped = 1'b1;
         rd[modem_dma_pkg::CTRL_W-1:0] = state_ff.ctrl;
      end
      else if (paddr == modem_dma_pkg::INT_STATUS_ADDR)
      begin
         mapped = 1'b1;
         rd[modem_dma_pkg::INT_W-1:0] = state_ff.int_status;
      end
      else if (paddr == modem_dma_pkg::INT_MASK_ADDR)
      begin
         mapped = 1'b1;
         rd[modem_dma_pkg::INT_W-1:0] = state_ff.int_mask;
      end
      // a misaligned byte offset is treated as unmapped
      if ((paddr & ~(modem_dma_pkg::BLOCK_MASK | modem_dma_pkg::INDEX_MASK)) != '0)
      begin
         mapped = 1'b0;
      end
      if (!mapped)
      begin
         rd = modem_dma_pkg::RDATA_ZERO;
      end

      // one wait state: pready rises after the first access cycle
      if (setup_done)
      begin
         nxt_state.pready = 1'b1;
         nxt_state.pslverr = !mapped;
         nxt_state.prdata = is_read ? rd : modem_dma_pkg::RDATA_ZERO;
      end
      else
      begin
         nxt_state.pready = 1'b0;
         nxt_state.pslverr = 1'b0;
         nxt_state.prdata = modem_dma_pkg::RDATA_ZERO;
      end

      // writes and read side effects land on the completing edge only
      if (access_end && mapped && pwrite)
      begin
         if (base == modem_dma_pkg::CKS_BASE)
         begin
            nxt_state.clock_select_field[idx] = pwdata[modem_dma_pkg::CKS_W-1:0];
         end
         else if (paddr == modem_dma_pkg::CTRL_ADDR)
         begin
            nxt_state.ctrl = pwdata[modem_dma_pkg::CTRL_W-1:0];
         end
         else if (paddr == modem_dma_pkg::INT_MASK_ADDR)
         begin
            nxt_state.int_mask = pwdata[modem_dma_pkg::INT_W-1:0];
         end
      end
      if (access_end && is_read && paddr == modem_dma_pkg::INT_STATUS_ADDR)
      begin
         int_clr = state_ff.int_status;
      end
      // an event in the clearing cycle survives
      nxt_state.int_status = (state_ff.int_status & ~int_clr) | int_set;
      nxt_state.irq = |(nxt_state.int_status & nxt_state.int_mask);
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_ff.prev <= modem_dma_pkg::MODEM_IDLE;
         // synchroniser idles high as well, so release makes no change event
         for (int c = 0; c < CH; c++)
         begin
            state_ff.flow[c] <= modem_dma_pkg::FLOW_RUN;
            state_ff.clock_select_field[c] <= modem_dma_pkg::CKS_RESET;
         end
         state_ff.ctrl <= modem_dma_pkg::CTRL_RESET;
         state_ff.int_status <= modem_dma_pkg::INT_RESET;
         state_ff.int_mask <= modem_dma_pkg::INT_RESET;
         state_ff.irq <= 1'b0;
         state_ff.pready <= 1'b0;
         state_ff.pslverr <= 1'b0;
         state_ff.prdata <= modem_dma_pkg::RDATA_ZERO;
         state_ff.core_out <= '0;
         state_ff.dma <= '1;
      end
      else
      begin
         state_ff <= nxt_state;
      end
   end

   assign prdata = state_ff.prdata;
   assign pready = state_ff.pready;
   assign pslverr = state_ff.pslverr;
   assign irq = state_ff.irq;
   assign core_out = state_ff.core_out;
   assign dma_pins = state_ff.dma;

endmodule

/* verif/modem_dma_checker.sv */
/*
   port checker for modem_dma_block: apb timing, dma pins, flow gating.
   assumes a single pclk domain with presetn as its reset.
*/
`timescale 1ns/1ps
module modem_dma_checker
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [31:0] prdata,
   input wire logic irq,
   input wire modem_dma_pkg::modem_pins_t modem_pins_n,
   input wire modem_dma_pkg::core_in_t core_in,
   input wire modem_dma_pkg::core_out_t core_out,
   input wire modem_dma_pkg::dma_pins_t dma_pins
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   ready_pulse_a: assert property (pready |=> !pready) else $error("pready too long");
   wait_state_a: assert property ((psel && !penable) ##1 (psel && penable) |=> pready)
      else $error("pready not in second access cycle");
   err_ready_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
   rdata_idle_a: assert property (!pready |-> prdata == 32'h00000000)
      else $error("prdata not zero");
   tx_any_a: assert property (dma_pins.tx_dma_ready_all_n == &dma_pins.tx_dma_ready_n)
      else $error("combined tx ready wrong");
   rx_any_a: assert property (dma_pins.rx_dma_ready_all_n == &dma_pins.rx_dma_ready_n)
      else $error("combined rx ready wrong");
   tx_follow_a: assert property (core_in.tx_dma_single == core_in.tx_dma_multi
      |=> dma_pins.tx_dma_ready_n == ~$past(core_in.tx_dma_single)) else $error("tx ready lag");
   rx_follow_a: assert property (core_in.rx_dma_single == core_in.rx_dma_multi
      |=> dma_pins.rx_dma_ready_n == ~$past(core_in.rx_dma_single)) else $error("rx ready lag");
   flow_char_a: assert property (1'b1 |=>
      (core_out.tx_go & $past(core_in.flow_char_pending)) == $past(core_in.flow_char_pending))
      else $error("flow character blocked");
   flow_run_a: assert property (((modem_pins_n.clear_to_send_n |
      modem_pins_n.data_set_ready_n) == 4'h0) [*5] |-> core_out.tx_go == 4'hF)
      else $error("transmitter held with lines asserted");
   tick_pulse_a: assert property (core_out.rx_clk_tick != 4'h0 |=>
      (core_out.rx_clk_tick & $past(core_out.rx_clk_tick)) == 4'h0) else $error("tick too long");
   irq_clear_a: assert property ($fell(irq) |->
      $past(psel && penable && pready) || $past(psel && penable && pready, 2))
      else $error("irq dropped without access");

   cover property (pslverr);
   cover property ($fell(core_out.tx_go[0]));
   cover property (core_out.tx_clk_tick[1]);
endmodule

bind modem_dma_block modem_dma_checker u_chk
(
   .pclk(pclk),
   .presetn(presetn),
   .psel(psel),
   .penable(penable),
   .pready(pready),
   .pslverr(pslverr),
   .prdata(prdata),
   .irq(irq),
   .modem_pins_n(modem_pins_n),
   .core_in(core_in),
   .core_out(core_out),
   .dma_pins(dma_pins)
);

/* verif/modem_model.sv */
/*
   far-side modem model: static line levels plus a gated 80 ns link clock.
   assumes the bench sets levels and per-channel clock enables.
*/
`timescale 1ns/1ps
module modem_model
(
   input wire modem_dma_pkg::modem_pins_t level_n,
   input wire logic [3:0] dsr_clk_en,
   input wire logic [3:0] ring_clk_en,
   output logic link_clk,
   output modem_dma_pkg::modem_pins_t pins_n
);
   logic [3:0] dsr_on;
   logic [3:0] ring_on;

   initial
   begin
      link_clk = 1'b0;
      dsr_on = 4'h0;
      ring_on = 4'h0;
      #7;
      forever #40 link_clk = ~link_clk;
   end

   // enables move only while the clock is low, so no runt pulses
   always @(negedge link_clk)
   begin
      dsr_on <= dsr_clk_en;
      ring_on <= ring_clk_en;
   end

   // outside frames the pin stands at its line level
   always_comb
   begin
      pins_n = level_n;
      for (int i = 0; i < 4; i++)
      begin
         if (dsr_on[i])
            pins_n.data_set_ready_n[i] = link_clk;
         if (ring_on[i])
            pins_n.ring_indicator_n[i] = link_clk;
      end
   end
endmodule

/* verif/tb.sv */
/*
   self-checking bench for modem_dma_block over apb.
   assumes modem_model on the line side; core levels driven here.
*/
`timescale 1ns/1ps
module tb;
   logic pclk;
   logic presetn;
   logic psel;
   logic penable;
   logic pwrite;
   logic [7:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic irq;
   modem_dma_pkg::modem_pins_t pins_n;
   modem_dma_pkg::modem_pins_t level_n;
   modem_dma_pkg::core_in_t core_in;
   modem_dma_pkg::core_out_t core_out;
   modem_dma_pkg::dma_pins_t dma_pins;
   logic [3:0] dsr_en;
   logic [3:0] ring_en;
   logic link_clk;
   logic [31:0] rd;
   logic err;
   int error_cnt = 0;
   int compares = 0;
   int tx_cnt [4] = '{0, 0, 0, 0};
   int rx_cnt [4] = '{0, 0, 0, 0};
   int tx0 [4];
   int rx0 [4];

   modem_dma_block u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .irq(irq), .modem_pins_n(pins_n), .core_in(core_in),
      .core_out(core_out), .dma_pins(dma_pins));
   modem_model u_modem (.level_n(level_n), .dsr_clk_en(dsr_en), .ring_clk_en(ring_en),
      .link_clk(link_clk), .pins_n(pins_n));

   initial
   begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   always @(posedge pclk)
   begin
      for (int i = 0; i < 4; i++)
      begin
         tx_cnt[i] += int'(core_out.tx_clk_tick[i] === 1'b1);
         rx_cnt[i] += int'(core_out.rx_clk_tick[i] === 1'b1);
      end
   end

   task automatic summarize();
      $display("compares %0d errors %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask

   // holds the request until pready is seen at an edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
      begin
         @(posedge pclk);
         n++;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      check("wait states", 32'(n), 1);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h00000000);
      check($sformatf("reg %h", a), rd, exp);
   endtask

   function automatic modem_dma_pkg::modem_pins_t pat(input int k);
      modem_dma_pkg::modem_pins_t p;
      p = modem_dma_pkg::MODEM_IDLE;
      for (int c = 0; c < 4; c++)
         case ((c + k) % 4)
            0: p.clear_to_send_n[c] = 1'b0;
            1: p.data_set_ready_n[c] = 1'b0;
            2: p.ring_indicator_n[c] = 1'b0;
            default: p.carrier_detect_n[c] = 1'b0;
         endcase
      return p;
   endfunction

   initial
   begin
      #200000;
      error_cnt++;
      summarize();
   end

   initial
   begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h00000000;
      core_in = '0;
      level_n = modem_dma_pkg::MODEM_IDLE;
      dsr_en = 4'h0;
      ring_en = 4'h0;
      cyc(3);
      presetn <= 1'b1;
      for (int i = 0; i < 6; i++)
         rdc(8'(4 * i + 16), 32'h00000000);
      // one pin kind per channel, rotated so each channel sees each kind
      for (int k = 0; k < 4; k++)
      begin
         @(posedge pclk);
         level_n <= pat(k);
         cyc(4);
         for (int c = 0; c < 4; c++)
            rdc(8'(4 * c), 32'h10 << ((c + k) % 4));
      end
      check("irq masked", 32'(irq), 0);
      apb(1'b1, 8'h28, 32'h000000FF);
      cyc(2);
      check("irq", 32'(irq), 1);
      rdc(8'h24, 32'h0000000F);
      cyc(2);
      check("irq cleared", 32'(irq), 0);
      apb(1'b1, 8'h28, 32'h00000000);
      @(posedge pclk);
      level_n <= '0;
      apb(1'b1, 8'h20, 32'h00000021);
      cyc(4);
      check("tx go", 32'(core_out.tx_go), 32'hF);
      core_in.tx_busy <= 4'h1;
      level_n.data_set_ready_n <= 4'h1;
      level_n.clear_to_send_n <= 4'h2;
      cyc(5);
      check("tx go", 32'(core_out.tx_go), 32'hC);
      rdc(8'h24, 32'h0000003F);
      core_in.flow_char_pending <= 4'h1;
      cyc(2);
      check("tx go", 32'(core_out.tx_go), 32'hD);
      core_in <= '0;
      cyc(3);
      check("tx go", 32'(core_out.tx_go), 32'hC);
      level_n <= '0;
      cyc(5);
      check("tx go", 32'(core_out.tx_go), 32'hF);
      for (int m = 0; m < 2; m++)
      begin
         apb(1'b1, 8'h20, m ? 32'h00000F00 : 32'h00000000);
         core_in.tx_dma_single <= 4'h8;
         core_in.tx_dma_multi <= 4'h1;
         core_in.rx_dma_single <= 4'h2;
         core_in.rx_dma_multi <= 4'h4;
         cyc(3);
         check("dma", 32'(dma_pins), m ? 32'h3AC : 32'h1F4);
         core_in <= '0;
         cyc(3);
         check("dma idle", 32'(dma_pins), 32'h3FF);
      end
      apb(1'b1, 8'h20, 32'h00000000);
      apb(1'b1, 8'h10, 32'h00000001);
      apb(1'b1, 8'h14, 32'h00000040);
      tx0 = tx_cnt;
      rx0 = rx_cnt;
      @(posedge link_clk);
      dsr_en <= 4'h1;
      ring_en <= 4'h2;
      repeat (4) @(posedge link_clk);
      dsr_en <= 4'h0;
      ring_en <= 4'h0;
      @(posedge pclk);
      core_in.baud_tick <= 4'h4;
      @(posedge pclk);
      core_in.baud_tick <= 4'h0;
      cyc(10);
      check("rx tick 0", 32'(rx_cnt[0] - rx0[0]), 4);
      check("tx tick 0", 32'(tx_cnt[0] - tx0[0]), 0);
      check("tx tick 1", 32'(tx_cnt[1] - tx0[1]), 4);
      check("rx tick 1", 32'(rx_cnt[1] - rx0[1]), 4);
      check("tx tick 2", 32'(tx_cnt[2] - tx0[2]), 1);
      apb(1'b0, 8'h2C, 32'h00000000);
      check("unmapped", {rd[30:0], err}, 1);
      apb(1'b0, 8'h01, 32'h00000000);
      check("misaligned", {rd[30:0], err}, 1);
      summarize();
   end
endmodule
